// file: src/spp_pkg.sv
// package: register map, field layout and carrier types for the shared port pin logic
// Functional notes
// - receiver enable forces receiver_active high and turns off receive pin driver
// - receive pin read gives pin level if direction zero, latch if one
// - buffered receive pin level always feeds the receiver, ignoring direction
// - direction bits load on write, read back, clear to zero at reset
// - transmit pin driver enabled by direction bit or transmitter_active
// - transmit pin read with direction one returns latch, even while transmitting
// - transmit pin read with direction zero returns buffered pin level
// - port write captures bus data into the per-pin output latches
// - transmit pin carries serial_tx_stream while transmitting, else the latch
// - open-drain select disables high-side drive on every pin together
// - transmitter_active stays high until the character in flight is done
// - after transmitting, direction bit and latch take the pin back
// - slave-out direction bit clears on reset and on sync_mode_fault
// - slave-out driver follows direction when sync off or slave, off as master
// - slave-out pin carries sync_slave_out_data while sync enabled, else latch
// - slave-out read returns driver data if enabled, else buffered pin level
// - buffered slave-out pin level always feeds the sync master data input
// - open-drain pin outputting one turns off low side too and floats
package spp_pkg;
  localparam int          SPP_PORT_W      = 4;
  localparam logic [11:0] SPP_OFF_PORT    = 12'h000;
  localparam logic [11:0] SPP_OFF_DIR     = 12'h004;
  localparam logic [11:0] SPP_OFF_CTRL    = 12'h008;
  localparam logic [11:0] SPP_OFF_STATUS  = 12'h00C;
  localparam int          SPP_BIT_RX      = 0;
  localparam int          SPP_BIT_TX      = 1;
  localparam int          SPP_BIT_SO      = 2;
  localparam int          SPP_CTRL_OD     = 0;
  localparam int          SPP_CTRL_RE     = 1;
  localparam int          SPP_CTRL_TE     = 2;
  localparam int          SPP_CTRL_SPE    = 3;
  localparam int          SPP_CTRL_SLV    = 4;
  localparam logic [3:0]  SPP_DIR_RST     = 4'h0;
  localparam logic [3:0]  SPP_LATCH_RST   = 4'h0;
  localparam logic [4:0]  SPP_CTRL_RST    = 5'h00;
  localparam int          SPP_CHAR_BITS   = 10;
  localparam int          SPP_BIT_CYCLES  = 16;

  typedef struct packed {
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
  } spp_pins_t;
endpackage

// file: src/spp_port.sv
// shared serial port pin logic with apb register access and a small transmitter
`timescale 1ns/1ns
module spp_port
  import spp_pkg::*;
#(
  parameter int CHAR_BITS  = SPP_CHAR_BITS,
  parameter int BIT_CYCLES = SPP_BIT_CYCLES
) (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [3:0]  pin_in,
  output spp_pins_t        pins_out,
  input  wire logic        sync_slave_out_data_in,
  input  wire logic        sync_mode_fault_in,
  output logic             sync_master_data_in_out,
  output logic             serial_rx_data_out,
  output logic             receiver_active_out,
  output logic             transmitter_active_out,
  output logic             tx_char_start_out
);

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} spp_tx_state_t;

  logic [3:0]    pin_s1_q, pin_s2_q;
  logic [3:0]    dir_q, latch_q;
  logic [4:0]    ctrl_q;
  logic [9:0]    tx_shift_q;
  logic [7:0]    tx_data_q;
  logic          tx_pend_q;
  logic [3:0]    tx_bits_q;
  logic [15:0]   tx_cnt_q;
  spp_tx_state_t tx_state_q;
  logic          apb_wr, apb_rd;
  logic [3:0]    drv_data, drv_en, read_val;
  logic          open_drain, rx_en, tx_en, sync_en, sync_slave, tx_active;
  logic [31:0]   rd_mux;

  // two flops before any logic sees the pins; the first stage is read only by the second
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign apb_wr      = psel_in & penable_in & pwrite_in;
  assign apb_rd      = psel_in & penable_in & ~pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = 1'b0;

  assign open_drain = ctrl_q[SPP_CTRL_OD];
  assign rx_en      = ctrl_q[SPP_CTRL_RE];
  assign tx_en      = ctrl_q[SPP_CTRL_TE];
  assign sync_en    = ctrl_q[SPP_CTRL_SPE];
  assign sync_slave = ctrl_q[SPP_CTRL_SLV];

  // direction bits; a mode fault wins over a write in the same cycle for the slave-out pin
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dir_q <= SPP_DIR_RST;
    end else begin
      if (apb_wr && paddr_in == SPP_OFF_DIR) begin
        dir_q <= pwdata_in[3:0];
      end
      if (sync_mode_fault_in) begin
        dir_q[SPP_BIT_SO] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      latch_q <= SPP_LATCH_RST;
    end else if (apb_wr && paddr_in == SPP_OFF_PORT) begin
      latch_q <= pwdata_in[3:0];
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_q <= SPP_CTRL_RST;
    end else if (apb_wr && paddr_in == SPP_OFF_CTRL) begin
      ctrl_q <= pwdata_in[4:0];
    end
  end

  // transmit data register: a write to the status offset queues one byte
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_data_q <= 8'h00;
      tx_pend_q <= 1'b0;
    end else begin
      if (tx_state_q == TX_IDLE && tx_pend_q && tx_en) begin
        tx_pend_q <= 1'b0;
      end
      if (apb_wr && paddr_in == SPP_OFF_STATUS) begin
        tx_data_q <= pwdata_in[7:0];
        tx_pend_q <= 1'b1;
      end
    end
  end

  // character framer: start bit, eight data bits lsb first, stop bit, then idle high
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 10'h3FF;
      tx_bits_q  <= 4'h0;
      tx_cnt_q   <= 16'h0000;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          if (tx_pend_q && tx_en) begin
            tx_shift_q <= {1'b1, tx_data_q, 1'b0};
            tx_bits_q  <= 4'(CHAR_BITS - 1);
            tx_cnt_q   <= 16'(BIT_CYCLES - 1);
            tx_state_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          // enable is not looked at here so a character in flight always completes
          if (tx_cnt_q != 16'h0000) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
          end else if (tx_bits_q != 4'h0) begin
            tx_cnt_q   <= 16'(BIT_CYCLES - 1);
            tx_bits_q  <= tx_bits_q - 4'h1;
            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
          end else begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  assign tx_active              = tx_en | (tx_state_q == TX_SHIFT);
  assign transmitter_active_out = tx_active;
  assign tx_char_start_out      = (tx_state_q == TX_IDLE) & tx_pend_q & tx_en;
  assign receiver_active_out    = rx_en;
  assign serial_rx_data_out     = pin_s2_q[SPP_BIT_RX];
  assign sync_master_data_in_out = pin_s2_q[SPP_BIT_SO];

  always_comb begin
    drv_data = latch_q;
    drv_en   = dir_q;
    drv_en[SPP_BIT_RX] = dir_q[SPP_BIT_RX] & ~rx_en;
    drv_en[SPP_BIT_TX] = dir_q[SPP_BIT_TX] | tx_active;
    if (tx_active) begin
      drv_data[SPP_BIT_TX] = tx_shift_q[0];
    end
    // slave-out drives only with direction set when off or slave; never as master
    drv_en[SPP_BIT_SO] = dir_q[SPP_BIT_SO] & (~sync_en | sync_slave);
    if (sync_en) begin
      drv_data[SPP_BIT_SO] = sync_slave_out_data_in;
    end
  end

  // open-drain: a driven one becomes high impedance, a driven zero still pulls low
  always_comb begin
    pins_out.pin_out = drv_data;
    pins_out.pin_oe  = drv_en & ~(open_drain ? drv_data : 4'h0);
  end

  always_comb begin
    read_val = pin_s2_q;
    read_val[SPP_BIT_RX] = dir_q[SPP_BIT_RX] ? latch_q[SPP_BIT_RX]
                                             : pin_s2_q[SPP_BIT_RX];
    read_val[SPP_BIT_TX] = dir_q[SPP_BIT_TX] ? latch_q[SPP_BIT_TX]
                                             : pin_s2_q[SPP_BIT_TX];
    read_val[SPP_BIT_SO] = drv_en[SPP_BIT_SO] ? drv_data[SPP_BIT_SO]
                                              : pin_s2_q[SPP_BIT_SO];
    read_val[3] = dir_q[3] ? latch_q[3] : pin_s2_q[3];
  end

  always_comb begin
    case (paddr_in)
      SPP_OFF_PORT:   rd_mux = {28'h0000000, read_val};
      SPP_OFF_DIR:    rd_mux = {28'h0000000, dir_q};
      SPP_OFF_CTRL:   rd_mux = {27'h0000000, ctrl_q};
      SPP_OFF_STATUS: rd_mux = {29'h0000000, tx_pend_q, tx_active, rx_en};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  // read data is registered so it is stable for the whole access phase edge
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_out <= 32'h00000000;
    end else if (psel_in & ~penable_in & ~pwrite_in) begin
      prdata_out <= rd_mux;
    end
  end

  // checker helpers: they feed no port logic and exist only for the properties below
  logic [1:0]  chk_warm_q;
  logic [15:0] chk_frame_cnt_q;

  // the synchroniser checks look two samples back, so they wait until both stages refill
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      chk_warm_q <= 2'b00;
    end else begin
      chk_warm_q <= {chk_warm_q[0], 1'b1};
    end
  end

  // cycles spent inside the current frame, cleared while the framer is idle
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      chk_frame_cnt_q <= 16'h0000;
    end else if (tx_state_q == TX_SHIFT) begin
      chk_frame_cnt_q <= chk_frame_cnt_q + 16'h0001;
    end else begin
      chk_frame_cnt_q <= 16'h0000;
    end
  end

  sequence s_frame_end;
    tx_state_q == TX_SHIFT ##1 tx_state_q == TX_IDLE;
  endsequence

  sequence s_dir_read_setup;
    psel_in && !penable_in && !pwrite_in && paddr_in == SPP_OFF_DIR;
  endsequence

  sequence s_so_input;
    !dir_q[SPP_BIT_SO] && !pins_out.pin_oe[SPP_BIT_SO];
  endsequence

  chk_rx_driver_off: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    rx_en |-> !pins_out.pin_oe[SPP_BIT_RX] && receiver_active_out)
    else $error("receive pin driven while receiver enabled");

  chk_rx_read_src: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    dir_q[SPP_BIT_RX] |-> read_val[SPP_BIT_RX] == latch_q[SPP_BIT_RX])
    else $error("receive pin read source wrong");
  chk_rx_read_pin: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !dir_q[SPP_BIT_RX] |-> read_val[SPP_BIT_RX] == pin_s2_q[SPP_BIT_RX])
    else $error("receive pin read not from pin");

  chk_rx_feed: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    chk_warm_q[1] |-> serial_rx_data_out == $past(pin_in[SPP_BIT_RX], 2))
    else $error("receiver not fed from pin");

  chk_dir_write: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    apb_wr && paddr_in == SPP_OFF_DIR && !sync_mode_fault_in |=> dir_q == $past(pwdata_in[3:0]))
    else $error("direction write lost");
  chk_dir_readback: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_dir_read_setup |=> prdata_out == {28'h0000000, $past(dir_q)})
    else $error("direction read back wrong");

  chk_tx_enable: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    drv_en[SPP_BIT_TX] == (dir_q[SPP_BIT_TX] | tx_active))
    else $error("transmit driver enable wrong");

  chk_tx_read_latch: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    dir_q[SPP_BIT_TX] |-> read_val[SPP_BIT_TX] == latch_q[SPP_BIT_TX])
    else $error("transmit pin read not from latch");

  chk_tx_read: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !dir_q[SPP_BIT_TX] |-> read_val[SPP_BIT_TX] == pin_s2_q[SPP_BIT_TX])
    else $error("transmit pin read wrong");

  chk_port_write: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    apb_wr && paddr_in == SPP_OFF_PORT |=> latch_q == $past(pwdata_in[3:0]))
    else $error("port latch not written");

  chk_tx_data_src: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    tx_active |-> pins_out.pin_out[SPP_BIT_TX] == tx_shift_q[0])
    else $error("transmit pin data wrong");
  chk_tx_idle_data: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !tx_active |-> pins_out.pin_out[SPP_BIT_TX] == latch_q[SPP_BIT_TX])
    else $error("transmit pin not from latch");
  chk_tx_start_bit: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    tx_char_start_out |=> pins_out.pin_out[SPP_BIT_TX] == 1'b0)
    else $error("start bit missing");

  chk_od_high: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    open_drain && drv_data[SPP_BIT_TX] |-> !pins_out.pin_oe[SPP_BIT_TX])
    else $error("open drain pin drove high");
  chk_od_all: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    open_drain |-> (pins_out.pin_oe & drv_data) == 4'h0)
    else $error("open drain port drove a one");
  chk_push_pull: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !open_drain |-> pins_out.pin_oe == drv_en)
    else $error("push pull enable wrong");
  chk_od_float: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    open_drain |-> pins_out.pin_oe == (drv_en & ~drv_data))
    else $error("open drain low side wrong");

  chk_tx_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    tx_state_q == TX_SHIFT && $fell(tx_en) |-> transmitter_active_out)
    else $error("character cut off");
  chk_frame_len: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_frame_end |-> chk_frame_cnt_q == 16'(CHAR_BITS * BIT_CYCLES))
    else $error("frame length wrong");
  chk_start_pulse: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    tx_char_start_out |=> !tx_char_start_out && transmitter_active_out)
    else $error("start pulse too long");

  chk_tx_release: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $fell(tx_active) |-> drv_en[SPP_BIT_TX] == dir_q[SPP_BIT_TX] && pins_out.pin_out[SPP_BIT_TX] == latch_q[SPP_BIT_TX])
    else $error("transmit pin not handed back");

  chk_so_fault: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    sync_mode_fault_in |=> s_so_input)
    else $error("fault did not clear slave-out direction");

  chk_so_master: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    sync_en && !sync_slave |-> !drv_en[SPP_BIT_SO])
    else $error("slave-out driven in master mode");
  chk_so_follow: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !sync_en || sync_slave |-> drv_en[SPP_BIT_SO] == dir_q[SPP_BIT_SO])
    else $error("slave-out enable not from direction");

  chk_so_data: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    sync_en |-> pins_out.pin_out[SPP_BIT_SO] == sync_slave_out_data_in)
    else $error("slave-out pin data wrong");
  chk_so_latch_data: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !sync_en |-> pins_out.pin_out[SPP_BIT_SO] == latch_q[SPP_BIT_SO])
    else $error("slave-out pin not from latch");

  chk_so_read: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !drv_en[SPP_BIT_SO] |-> read_val[SPP_BIT_SO] == pin_s2_q[SPP_BIT_SO])
    else $error("slave-out read wrong");
  chk_so_read_drv: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    drv_en[SPP_BIT_SO] |-> read_val[SPP_BIT_SO] == drv_data[SPP_BIT_SO])
    else $error("slave-out read not from driver");

  chk_so_feed: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    chk_warm_q[1] |-> sync_master_data_in_out == $past(pin_in[SPP_BIT_SO], 2))
    else $error("sync data input not from pin");

endmodule

// file: verification/spp_far_model.sv
// far-side model: external devices sharing the port pins, with pull-ups
`timescale 1ns/1ns
module spp_far_model
  import spp_pkg::*;
(
  input  wire spp_pins_t  pins_in,
  input  wire logic [3:0] ext_en_in,
  input  wire logic [3:0] ext_val_in,
  output logic      [3:0] pin_lvl_out
);
  // port wins where both drive; a released pin floats up to the pull-up level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pins_in.pin_oe[i]) begin
        pin_lvl_out[i] = pins_in.pin_out[i];
      end else if (ext_en_in[i]) begin
        pin_lvl_out[i] = ext_val_in[i];
      end else begin
        pin_lvl_out[i] = 1'b1;
      end
    end
  end
endmodule

// file: verification/tb.sv
// self-checking testbench for the shared serial port pin logic
`timescale 1ns/1ns
module tb
  import spp_pkg::*;
;
  logic clk, rst, psel, pen, pwr, pready, pslverr, so_d, mflt, mdin, rxd, ract, tact, tst;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  lvl, ext_en, ext_val;
  spp_pins_t   pins;
  int          n_fail, samples_checked;

  spp_port #(.BIT_CYCLES(2)) spp_port_i (.sys_clk_in(clk), .reset_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pin_in(lvl),
    .pins_out(pins), .sync_slave_out_data_in(so_d), .sync_mode_fault_in(mflt),
    .sync_master_data_in_out(mdin), .serial_rx_data_out(rxd), .receiver_active_out(ract),
    .transmitter_active_out(tact), .tx_char_start_out(tst));
  spp_far_model spp_far_model_i (.pins_in(pins), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .pin_lvl_out(lvl));

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    chk({pready, pslverr}, 2'b10);
    psel <= 1'b0; pen <= 1'b0;
    // outputs are looked at mid-cycle, once the access edge has settled them
    @(negedge clk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic t_reset;
    apb(0, SPP_OFF_DIR, 0); chk(r, 0);
    chk({28'h0, pins.pin_oe}, 0);
    apb(0, 12'h010, 0); chk(r, 0);
  endtask

  task automatic t_latch;
    apb(1, SPP_OFF_PORT, 32'h5); apb(1, SPP_OFF_DIR, 32'hF);
    apb(0, SPP_OFF_DIR, 0); chk(r, 32'hF);
    chk({28'h0, pins.pin_out}, 32'h5);
    chk({28'h0, pins.pin_oe}, 32'hF);
    apb(0, SPP_OFF_PORT, 0); chk(r, 32'h5);
  endtask

  task automatic t_rx;
    apb(1, SPP_OFF_CTRL, 1 << SPP_CTRL_RE);
    chk(ract, 1);
    chk(pins.pin_oe[SPP_BIT_RX], 0);
    @(posedge clk); ext_en <= 4'h1; ext_val <= 4'h0;
    cyc(4); chk(rxd, 0);
    apb(0, SPP_OFF_PORT, 0); chk(r[0], 1);
    apb(1, SPP_OFF_CTRL, 0);
  endtask

  task automatic t_input;
    apb(1, SPP_OFF_DIR, 0);
    @(posedge clk); ext_en <= 4'hF; ext_val <= 4'hA;
    cyc(4); apb(0, SPP_OFF_PORT, 0); chk(r, 32'hA);
    chk(mdin, 0);
    @(posedge clk); ext_val <= 4'h5;
    cyc(4); apb(0, SPP_OFF_PORT, 0); chk(r, 32'h5);
    chk(mdin, 1);
    @(posedge clk); ext_en <= 4'h0;
  endtask

  task automatic t_od;
    apb(1, SPP_OFF_DIR, 32'hF); apb(1, SPP_OFF_CTRL, 1 << SPP_CTRL_OD);
    chk({28'h0, pins.pin_oe}, 32'hA);
    chk({28'h0, pins.pin_out & pins.pin_oe}, 0);
    apb(1, SPP_OFF_CTRL, 0);
  endtask

  task automatic t_sync;
    apb(1, SPP_OFF_CTRL, (1 << SPP_CTRL_SPE) | (1 << SPP_CTRL_SLV));
    apb(1, SPP_OFF_DIR, 32'hF);
    @(posedge clk); so_d <= 1'b1;
    cyc(1); chk(pins.pin_out[SPP_BIT_SO], 1);
    chk(pins.pin_oe[SPP_BIT_SO], 1);
    @(posedge clk); so_d <= 1'b0;
    apb(0, SPP_OFF_PORT, 0); chk(r[SPP_BIT_SO], 0);
    apb(1, SPP_OFF_CTRL, 1 << SPP_CTRL_SPE);
    chk(pins.pin_oe[SPP_BIT_SO], 0);
    @(posedge clk); ext_en <= 4'h4; ext_val <= 4'h4;
    cyc(4); apb(0, SPP_OFF_PORT, 0); chk(r[SPP_BIT_SO], 1);
    @(posedge clk); mflt <= 1'b1;
    @(posedge clk); mflt <= 1'b0;
    apb(0, SPP_OFF_DIR, 0); chk(r[SPP_BIT_SO], 0);
    @(posedge clk); ext_en <= 4'h0;
    apb(1, SPP_OFF_CTRL, 0);
  endtask

  task automatic t_tx;
    int n;
    logic saw0;
    n = 0;
    saw0 = 0;
    apb(1, SPP_OFF_DIR, 0); apb(1, SPP_OFF_PORT, 32'hF);
    apb(1, SPP_OFF_CTRL, 1 << SPP_CTRL_TE); apb(1, SPP_OFF_STATUS, 32'hA5);
    while (tact !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(pins.pin_oe[SPP_BIT_TX], 1);
    // clearing the enable mid-character must not cut the frame short
    apb(1, SPP_OFF_CTRL, 0); chk(tact, 1);
    n = 0;
    while (tact === 1'b1 && n < 100) begin
      if (pins.pin_out[SPP_BIT_TX] === 1'b0) saw0 = 1;
      @(posedge clk);
      n++;
    end
    chk(saw0, 1);
    chk(pins.pin_oe[SPP_BIT_TX], 0);
    apb(1, SPP_OFF_DIR, 32'h2);
    chk({pins.pin_oe[SPP_BIT_TX], pins.pin_out[SPP_BIT_TX]}, 2'b11);
  endtask

  task automatic t_tx_latch;
    int n;
    n = 0;
    apb(1, SPP_OFF_DIR, 32'h2); apb(1, SPP_OFF_PORT, 32'h0);
    apb(1, SPP_OFF_CTRL, 1 << SPP_CTRL_TE); apb(1, SPP_OFF_STATUS, 32'hFF);
    chk(tst, 1);
    apb(1, SPP_OFF_CTRL, 0); chk(tst, 0);
    cyc(4); apb(0, SPP_OFF_PORT, 0); chk(r[SPP_BIT_TX], 0);
    chk(pins.pin_out[SPP_BIT_TX], 1);
    chk(tact, 1);
    while (tact === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    chk(tact, 0);
    chk({pins.pin_oe[SPP_BIT_TX], pins.pin_out[SPP_BIT_TX]}, 2'b10);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk = 0; rst = 1; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0;
    so_d = 0; mflt = 0; ext_en = 0; ext_val = 0; n_fail = 0; samples_checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset; t_latch; t_rx; t_input; t_od; t_sync; t_tx; t_tx_latch;
    wrap_up;
  end

  initial begin
    #200000;
    n_fail++;
    wrap_up;
  end
endmodule
